// ---- core/dimb_pkg.sv ----
// shared constants, types and decode for the dma interrupt mask bank
package dimb_pkg;

  // geometry
  localparam int unsigned CH_N  = 3;
  localparam int unsigned SET_N = 4;
  localparam int unsigned OFS_W = 12;

  // register offsets from the controller base
  localparam logic [11:0] OFS_BLOCK_DONE_MASK       = 12'h318;
  localparam logic [11:0] OFS_BLOCK_DONE_MASK_UPPER = 12'h31C;
  localparam logic [11:0] OFS_SOURCE_DONE_MASK      = 12'h320;
  localparam logic [11:0] OFS_SOURCE_DONE_MASK_UPPER = 12'h324;
  localparam logic [11:0] OFS_DEST_DONE_MASK        = 12'h328;
  localparam logic [11:0] OFS_DEST_DONE_MASK_UPPER  = 12'h32C;
  localparam logic [11:0] OFS_FAULT_MASK            = 12'h330;

  // field positions inside a low mask register
  localparam int unsigned MASK_LSB  = 0;
  localparam int unsigned WR_EN_LSB = 8;

  // values after reset
  localparam logic [CH_N-1:0] MASK_RST  = 3'h0;
  localparam logic [31:0]     RDATA_RST = 32'h0000_0000;

  // mask set indices
  localparam logic [1:0] SET_BLOCK  = 2'h0;
  localparam logic [1:0] SET_SOURCE = 2'h1;
  localparam logic [1:0] SET_DEST   = 2'h2;
  localparam logic [1:0] SET_FAULT  = 2'h3;

  // bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // data-phase sequencer of the bus slave
  typedef enum {DP_IDLE, DP_ERR_FIRST, DP_ERR_LAST} dimb_dphase_e;

  typedef struct packed {
    logic       mask_hit;
    logic       rsvd_hit;
    logic [1:0] set;
  } dimb_dec_s;

  function automatic dimb_dec_s dimb_decode(input logic [OFS_W-1:0] ofs);
    dimb_dec_s d;
    d = '0;
    case (ofs)
      OFS_BLOCK_DONE_MASK:        begin d.mask_hit = 1'b1; d.set = SET_BLOCK;  end
      OFS_SOURCE_DONE_MASK:       begin d.mask_hit = 1'b1; d.set = SET_SOURCE; end
      OFS_DEST_DONE_MASK:         begin d.mask_hit = 1'b1; d.set = SET_DEST;   end
      OFS_FAULT_MASK:             begin d.mask_hit = 1'b1; d.set = SET_FAULT;  end
      OFS_BLOCK_DONE_MASK_UPPER,
      OFS_SOURCE_DONE_MASK_UPPER,
      OFS_DEST_DONE_MASK_UPPER:   d.rsvd_hit = 1'b1;
      default:                    d = '0;
    endcase
    return d;
  endfunction : dimb_decode

endpackage : dimb_pkg

// ---- core/dimb_mask_if.sv ----
// write port and stored value of one per-channel mask set
`timescale 1ns/1ps
interface dimb_mask_if #(
  parameter int unsigned CH = 3
);
  logic          wr_stb;
  logic [CH-1:0] wr_mask;
  logic [CH-1:0] wr_en;
  logic [CH-1:0] mask_cur;
  logic [CH-1:0] mask_next;

  modport ctrl  (output wr_stb, output wr_mask, output wr_en,
                 input mask_cur, input mask_next);
  modport store (input wr_stb, input wr_mask, input wr_en,
                 output mask_cur, output mask_next);
endinterface : dimb_mask_if

// ---- core/dimb_mask_reg.sv ----
// one mask set: a bit changes only when its own write enable is set
`timescale 1ns/1ps
module dimb_mask_reg #(
  parameter int unsigned CH = 3
) (
  // clock and reset
  input wire logic   sys_clk,
  input wire logic   srst,
  // write port and stored mask
  dimb_mask_if.store mif
);

  logic [CH-1:0] mask_r;
  logic [CH-1:0] mask_nxt;

  always_comb begin
    mask_nxt = mask_r;
    for (int i = 0; i < CH; i++) begin
      // enable clear leaves the bit alone, so no read-modify-write is needed
      if (mif.wr_stb && mif.wr_en[i]) begin
        mask_nxt[i] = mif.wr_mask[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mask_r <= CH'(dimb_pkg::MASK_RST);
    end else begin
      mask_r <= mask_nxt;
    end
  end

  assign mif.mask_cur  = mask_r;
  assign mif.mask_next = mask_nxt;

endmodule : dimb_mask_reg

// ---- core/dimb_top.sv ----
// dma interrupt mask bank: ahb slave, four mask sets and event gating
//
// Overview of operation
// - block done mask, bits 2:0, reset zero
// - source done mask, bits 2:0, reset zero
// - destination done mask, bits 2:0, reset zero
// - fault mask, bits 2:0, one unmasks
// - mask bit written only with its enable
// - cleared enable keeps stored mask unchanged
`timescale 1ns/1ps
module dimb_top #(
  parameter int unsigned CH = dimb_pkg::CH_N
) (
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          srst,
  // ahb slave
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic               hresp,
  output logic [31:0]        hrdata,
  // raw channel events, one bit per channel
  input  wire logic [CH-1:0] evt_block_done,
  input  wire logic [CH-1:0] evt_source_done,
  input  wire logic [CH-1:0] evt_dest_done,
  input  wire logic [CH-1:0] evt_fault,
  // gated events and combined interrupt
  output logic [CH-1:0]      irq_block_done,
  output logic [CH-1:0]      irq_source_done,
  output logic [CH-1:0]      irq_dest_done,
  output logic [CH-1:0]      irq_fault,
  output logic               dma_irq
);

  localparam int unsigned SET_N = dimb_pkg::SET_N;

  // address phase
  logic                  ap_take;
  dimb_pkg::dimb_dec_s   ap_dec;
  logic                  ap_hit;

  // data phase state
  dimb_pkg::dimb_dphase_e dp_state_r;
  dimb_pkg::dimb_dphase_e dp_state_nxt;
  logic                  dp_wr_r;
  logic                  dp_wr_nxt;
  logic [1:0]            dp_set_r;
  logic [1:0]            dp_set_nxt;
  logic [31:0]           hrdata_r;
  logic [31:0]           hrdata_nxt;

  // mask sets
  logic [CH-1:0]         mask_now  [SET_N];
  logic [CH-1:0]         mask_fwd  [SET_N];
  logic [CH-1:0]         evt_set   [SET_N];

  // gated outputs
  logic [CH-1:0]         gated_r   [SET_N];
  logic [CH-1:0]         gated_nxt [SET_N];
  logic                  irq_r;
  logic                  irq_nxt;

  assign ap_take = hsel && htrans[1] && hready;
  assign ap_dec  = dimb_pkg::dimb_decode(haddr[dimb_pkg::OFS_W-1:0]);
  assign ap_hit  = ap_dec.mask_hit || ap_dec.rsvd_hit;

  assign evt_set[dimb_pkg::SET_BLOCK]  = evt_block_done;
  assign evt_set[dimb_pkg::SET_SOURCE] = evt_source_done;
  assign evt_set[dimb_pkg::SET_DEST]   = evt_dest_done;
  assign evt_set[dimb_pkg::SET_FAULT]  = evt_fault;

  // one mask register per event class
  for (genvar g = 0; g < SET_N; g++) begin : g_set
    dimb_mask_if #(.CH(CH)) mif ();

    // write lands in the data phase, when hwdata is on the bus
    assign mif.wr_stb  = dp_wr_r && (dp_set_r == 2'(g));
    assign mif.wr_en   = hwdata[dimb_pkg::WR_EN_LSB +: CH];
    assign mif.wr_mask = hwdata[dimb_pkg::MASK_LSB +: CH];
    assign mask_now[g] = mif.mask_cur;
    assign mask_fwd[g] = mif.mask_next;

    dimb_mask_reg #(.CH(CH)) u_mask (
      .sys_clk (sys_clk),
      .srst    (srst),
      .mif     (mif.store)
    );
  end

  // bus slave: zero wait on mapped offsets, two-cycle error elsewhere
  always_comb begin
    dp_state_nxt = dp_state_r;
    dp_wr_nxt    = 1'b0;
    dp_set_nxt   = dp_set_r;
    hrdata_nxt   = hrdata_r;
    case (dp_state_r)
      dimb_pkg::DP_IDLE: begin
        if (ap_take && !ap_hit) begin
          dp_state_nxt = dimb_pkg::DP_ERR_FIRST;
        end
      end
      dimb_pkg::DP_ERR_FIRST: begin
        dp_state_nxt = dimb_pkg::DP_ERR_LAST;
      end
      dimb_pkg::DP_ERR_LAST: begin
        if (ap_take && !ap_hit) begin
          dp_state_nxt = dimb_pkg::DP_ERR_FIRST;
        end else begin
          dp_state_nxt = dimb_pkg::DP_IDLE;
        end
      end
      default: begin
        dp_state_nxt = dimb_pkg::DP_IDLE;
      end
    endcase
    if (ap_take) begin
      hrdata_nxt = dimb_pkg::RDATA_RST;
      if (ap_hit) begin
        // narrow writes are ignored: mask and enable lanes must arrive together
        dp_wr_nxt  = hwrite && ap_dec.mask_hit && (hsize == dimb_pkg::HSIZE_WORD);
        dp_set_nxt = ap_dec.set;
        if (!hwrite && ap_dec.mask_hit) begin
          // forwarded value covers a write in the data phase now ending
          hrdata_nxt[dimb_pkg::MASK_LSB +: CH] = mask_fwd[ap_dec.set];
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dp_state_r <= dimb_pkg::DP_IDLE;
      dp_wr_r    <= 1'b0;
      dp_set_r   <= dimb_pkg::SET_BLOCK;
      hrdata_r   <= dimb_pkg::RDATA_RST;
    end else begin
      dp_state_r <= dp_state_nxt;
      dp_wr_r    <= dp_wr_nxt;
      dp_set_r   <= dp_set_nxt;
      hrdata_r   <= hrdata_nxt;
    end
  end

  assign hreadyout = (dp_state_r != dimb_pkg::DP_ERR_FIRST);
  assign hresp     = (dp_state_r != dimb_pkg::DP_IDLE);
  assign hrdata    = hrdata_r;

  // event gating; raw status lives upstream and is untouched by the mask
  always_comb begin
    irq_nxt = 1'b0;
    for (int s = 0; s < SET_N; s++) begin
      gated_nxt[s] = evt_set[s] & mask_now[s];
      irq_nxt      = irq_nxt | (|gated_nxt[s]);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      irq_r <= 1'b0;
      for (int s = 0; s < SET_N; s++) begin
        gated_r[s] <= '0;
      end
    end else begin
      irq_r <= irq_nxt;
      for (int s = 0; s < SET_N; s++) begin
        gated_r[s] <= gated_nxt[s];
      end
    end
  end

  assign irq_block_done  = gated_r[dimb_pkg::SET_BLOCK];
  assign irq_source_done = gated_r[dimb_pkg::SET_SOURCE];
  assign irq_dest_done   = gated_r[dimb_pkg::SET_DEST];
  assign irq_fault       = gated_r[dimb_pkg::SET_FAULT];
  assign dma_irq         = irq_r;

endmodule : dimb_top

// ---- tb/dimb_asserts.sv ----
// assertions on the mask bank's bus answers and gated events
`timescale 1ns/1ps
module dimb_asserts #(
  parameter int unsigned CH = 3
) (
  // clock and reset
  input wire logic          sys_clk,
  input wire logic          srst,
  // bus
  input wire logic          hsel,
  input wire logic [31:0]   haddr,
  input wire logic [1:0]    htrans,
  input wire logic          hready,
  input wire logic          hreadyout,
  input wire logic          hresp,
  // events in and out
  input wire logic [CH-1:0] evt_block_done,
  input wire logic [CH-1:0] evt_source_done,
  input wire logic [CH-1:0] evt_dest_done,
  input wire logic [CH-1:0] evt_fault,
  input wire logic [CH-1:0] irq_block_done,
  input wire logic [CH-1:0] irq_source_done,
  input wire logic [CH-1:0] irq_dest_done,
  input wire logic [CH-1:0] irq_fault,
  input wire logic          dma_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic tk;
  logic ok;
  assign tk = hsel && htrans[1] && hready;
  // upper words are mapped too: they answer okay and read zero
  assign ok = haddr[11:0] inside {12'h318, 12'h31C, 12'h320, 12'h324,
                                  12'h328, 12'h32C, 12'h330};
  sequence s_err;
    !hreadyout && hresp ##1 hreadyout && hresp;
  endsequence
  a_blk_cause: assert property ((irq_block_done & ~$past(evt_block_done)) == '0)
    else $error("block irq without event");
  a_src_cause: assert property ((irq_source_done & ~$past(evt_source_done)) == '0)
    else $error("source irq without event");
  a_dst_cause: assert property ((irq_dest_done & ~$past(evt_dest_done)) == '0)
    else $error("dest irq without event");
  a_flt_cause: assert property ((irq_fault & ~$past(evt_fault)) == '0)
    else $error("fault irq without event");
  a_irq_merge: assert property (
    dma_irq == |{irq_block_done, irq_source_done, irq_dest_done, irq_fault})
    else $error("combined irq differs");
  a_rst_quiet: assert property ($past(srst) |-> !dma_irq)
    else $error("irq after reset");
  a_ok_nowait: assert property (tk && ok |=> hreadyout && !hresp)
    else $error("mapped access not okay");
  a_bad_error: assert property (tk && !ok |=> s_err)
    else $error("unmapped access without error");
endmodule : dimb_asserts

// ---- tb/dimb_host.sv ----
// bus master standing in for the host processor
`timescale 1ns/1ps
module dimb_host (
  // clock
  input wire logic    sys_clk,
  // requests
  output logic        hsel,
  output logic [31:0] haddr,
  output logic [1:0]  htrans,
  output logic        hwrite,
  output logic [2:0]  hsize,
  output logic [31:0] hwdata,
  // answers
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end
  // released lines show the inverse so stale values never look valid
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      input logic [2:0] sz, output logic [31:0] rd, output logic rsp);
    int n;
    @(negedge sys_clk);
    hsel   = 1'b1;
    htrans = 2'h2;
    hwrite = w;
    hsize  = sz;
    haddr  = a;
    @(negedge sys_clk);
    hsel   = 1'b0;
    htrans = 2'h0;
    haddr  = ~a;
    hwdata = d;
    n = 0;
    // answers are read at the falling edge, settled until the rising edge that ends the phase
    while (hreadyout !== 1'b1 && n < 4) begin
      @(negedge sys_clk);
      n++;
    end
    rd  = hrdata;
    rsp = hresp;
    @(posedge sys_clk);
    @(negedge sys_clk);
    hwdata = ~d;
  endtask : xfer
  // write then read of one register back to back; mapped offsets only, they never wait
  task automatic wr_rd(input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
    @(negedge sys_clk);
    hsel   = 1'b1;
    htrans = 2'h2;
    hwrite = 1'b1;
    hsize  = 3'h2;
    haddr  = a;
    @(negedge sys_clk);
    hwrite = 1'b0;
    hwdata = d;
    @(negedge sys_clk);
    hsel   = 1'b0;
    htrans = 2'h0;
    haddr  = ~a;
    hwdata = ~d;
    rd     = hrdata;
    @(posedge sys_clk);
  endtask : wr_rd
endmodule : dimb_host

// ---- tb/tb.sv ----
// self-checking bench for the dma interrupt mask bank
`timescale 1ns/1ps
module tb;
  logic             sys_clk;
  logic             srst;
  logic             hsel;
  logic [31:0]      haddr;
  logic [1:0]       htrans;
  logic             hwrite;
  logic [2:0]       hsize;
  logic [31:0]      hwdata;
  logic             hreadyout;
  logic             hresp;
  logic [31:0]      hrdata;
  logic             dma_irq;
  logic [3:0][2:0]  ev;
  wire  [3:0][2:0]  irq;
  logic [11:0]      ofs [4];
  int               mismatches;
  int               compares;
  int               cyc;
  logic [31:0]      rdv;
  logic             rsv;
  dimb_top dut (.sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .evt_block_done(ev[0]),
    .evt_source_done(ev[1]), .evt_dest_done(ev[2]), .evt_fault(ev[3]),
    .irq_block_done(irq[0]), .irq_source_done(irq[1]), .irq_dest_done(irq[2]),
    .irq_fault(irq[3]), .dma_irq(dma_irq));
  dimb_host host (.sys_clk(sys_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic xf(input logic w, input logic [31:0] a, input logic [31:0] d,
                    input logic [31:0] e, input logic er);
    logic [31:0] r;
    logic        s;
    host.xfer(w, a, d, dimb_pkg::HSIZE_WORD, r, s);
    chk("resp", {31'h0, s}, {31'h0, er});
    if (!w) chk("rdata", r, e);
  endtask : xf
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      mismatches++;
      test_done();
    end
  end
  initial begin
    srst = 1'b1;
    ev = '0;
    ofs = '{dimb_pkg::OFS_BLOCK_DONE_MASK, dimb_pkg::OFS_SOURCE_DONE_MASK,
            dimb_pkg::OFS_DEST_DONE_MASK, dimb_pkg::OFS_FAULT_MASK};
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    srst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      xf(1'b0, {20'h0, ofs[i]}, 32'h0, 32'h0, 1'b0);
      // only channel 0 is enabled, so the set mask bit of channel 2 is dropped
      xf(1'b1, {20'h0, ofs[i]}, 32'h0000_0105, 32'h0, 1'b0);
      xf(1'b0, {20'h0, ofs[i]}, 32'h0, 32'h1, 1'b0);
      xf(1'b1, {20'h0, ofs[i]}, 32'h0000_0602, 32'h0, 1'b0);
      xf(1'b0, {20'h0, ofs[i]}, 32'h0, 32'h3, 1'b0);
      xf(1'b1, {20'h0, ofs[i]}, 32'hFFFF_F8F8, 32'h0, 1'b0);
      xf(1'b0, {20'h0, ofs[i]}, 32'h0, 32'h3, 1'b0);
    end
    xf(1'b1, 32'h0000_031C, 32'hFFFF_FFFF, 32'h0, 1'b0);
    xf(1'b0, 32'h0000_031C, 32'h0, 32'h0, 1'b0);
    xf(1'b1, 32'h0000_0400, 32'h0000_0707, 32'h0, 1'b1);
    xf(1'b1, 32'h0000_0319, 32'h0000_0707, 32'h0, 1'b1);
    xf(1'b0, 32'h0000_0318, 32'h0, 32'h3, 1'b0);
    // a byte write is answered okay but must not touch the mask
    host.xfer(1'b1, 32'h0000_0318, 32'h0000_0704, 3'h0, rdv, rsv);
    chk("narrow_resp", {31'h0, rsv}, 32'h0);
    xf(1'b0, 32'h0000_0318, 32'h0, 32'h3, 1'b0);
    ev = {4{3'h7}};
    repeat (2) @(negedge sys_clk);
    for (int i = 0; i < 4; i++) chk("irq", {29'h0, irq[i]}, 32'h3);
    chk("dma_irq", {31'h0, dma_irq}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      xf(1'b1, {20'h0, ofs[i]}, 32'h0000_0700, 32'h0, 1'b0);
      repeat (2) @(negedge sys_clk);
      chk("irq_masked", {29'h0, irq[i]}, 32'h0);
    end
    chk("dma_irq_masked", {31'h0, dma_irq}, 32'h0);
    // read right behind a write returns the mask bits just written, with the enable lanes reading zero
    host.wr_rd({20'h0, ofs[1]}, 32'h0000_0707, rdv);
    chk("fwd_rdata", rdv, 32'h7);
    repeat (2) @(negedge sys_clk);
    chk("irq_unmasked", {29'h0, irq[1]}, 32'h7);
    chk("dma_irq_unmasked", {31'h0, dma_irq}, 32'h1);
    test_done();
  end
endmodule : tb
bind dimb_top dimb_asserts #(.CH(CH)) u_chk (.sys_clk(sys_clk), .srst(srst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .evt_block_done(evt_block_done), .evt_source_done(evt_source_done),
  .evt_dest_done(evt_dest_done), .evt_fault(evt_fault), .irq_block_done(irq_block_done),
  .irq_source_done(irq_source_done), .irq_dest_done(irq_dest_done),
  .irq_fault(irq_fault), .dma_irq(dma_irq));
